//--- nvs_cfg.svh
// Constants and timing counts of the store/recall sequencer
// Assumes a 10 MHz system clock; includers use the macros by name
//
// Contract
// - Skip pin or power-loss save without dirty data
// - Accept pending write 25 ns after save start
// - Ignore accesses during save, restore, low supply
// - Block bus until save 8 ms, restore 600 us
// - Act on software command within 500 us
// - Keep SRAM disabled while pin held low
// - Become active within 5 us after release
// - Clean pin save leaves driver disabled
// - Drive pin high at most 500 ns
// - Wake from sleep within 20 ms
// - Enter sleep within 8 ms of instruction
// - Enter standby within 100 us after stop
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH

// ----------------------------------------
// Clock rate
// ----------------------------------------
`define NVS_CLK_HZ 10000000

// ----------------------------------------
// Times as printed, in their own units
// ----------------------------------------
`define NVS_STORE_MS 8
`define NVS_RECALL_US 600
`define NVS_WRITE_GRACE_NS 25
`define NVS_CMD_PROC_US 500
`define NVS_SAVE_PULSE_MIN_NS 15
`define NVS_REL_ACTIVE_US 5
`define NVS_HIGH_DRIVE_NS 500
`define NVS_WAKE_MS 20
`define NVS_SLEEP_MS 8
`define NVS_STANDBY_US 100

// ----------------------------------------
// Cycle counts; nanosecond times round down, floor one cycle
// ----------------------------------------
`define NVS_MAXC(x) (((x) < 1) ? 1 : (x))
`define NVS_STORE_CYC `NVS_MAXC(`NVS_STORE_MS * (`NVS_CLK_HZ / 1000))
`define NVS_RECALL_CYC `NVS_MAXC(`NVS_RECALL_US * (`NVS_CLK_HZ / 1000000))
`define NVS_GRACE_CYC `NVS_MAXC((`NVS_WRITE_GRACE_NS * (`NVS_CLK_HZ / 1000000)) / 1000)
`define NVS_CMD_CYC `NVS_MAXC(`NVS_CMD_PROC_US * (`NVS_CLK_HZ / 1000000))
`define NVS_REL_CYC `NVS_MAXC(`NVS_REL_ACTIVE_US * (`NVS_CLK_HZ / 1000000))
`define NVS_HIGH_CYC `NVS_MAXC((`NVS_HIGH_DRIVE_NS * (`NVS_CLK_HZ / 1000000)) / 1000)
`define NVS_WAKE_CYC `NVS_MAXC(`NVS_WAKE_MS * (`NVS_CLK_HZ / 1000))
`define NVS_SLEEP_CYC `NVS_MAXC(`NVS_SLEEP_MS * (`NVS_CLK_HZ / 1000))
`define NVS_STANDBY_CYC `NVS_MAXC(`NVS_STANDBY_US * (`NVS_CLK_HZ / 1000000))
// Pin sync and state steps taken out of the release count
`define NVS_REL_LAT 4

// ----------------------------------------
// Counter width
// ----------------------------------------
`define NVS_CW 18

`endif

//--- nvs_pkg.sv
// Types of the store/recall sequencer
// Assumes nvs_cfg.svh is on the include path
package nvs_pkg;
  typedef enum logic [3:0] {
    NVS_IDLE = 4'h0,
    NVS_CMD = 4'h1,
    NVS_GRACE = 4'h2,
    NVS_STORE = 4'h3,
    NVS_RECALL = 4'h4,
    NVS_HIGH = 4'h5,
    NVS_HOLD = 4'h6,
    NVS_REL = 4'h7,
    NVS_SLP_IN = 4'h8,
    NVS_SLEEP = 4'h9,
    NVS_WAKE = 4'ha
  } nvs_state_t;

  typedef enum logic [1:0] {
    NVS_OP_NONE = 2'h0,
    NVS_OP_STORE = 2'h1,
    NVS_OP_RECALL = 2'h2,
    NVS_OP_SLEEP = 2'h3
  } nvs_op_t;
endpackage : nvs_pkg

//--- nvs_timer.sv
// Down counter giving a one-cycle done pulse after a loaded count
// Assumes same clock and reset as its user
`timescale 1ns/1ps
`default_nettype none
module nvs_timer #(
  parameter int W = 18
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done,
  output logic running
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_done;
  logic next_running;

  // ----------------------------------------
  // Next count
  // ----------------------------------------
  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    next_running = running;
    if (load) begin
      next_cnt = count;
      next_running = 1'b1;
    end else if (running) begin
      if (cnt <= W'(1)) begin
        next_done = 1'b1;
        next_running = 1'b0;
        next_cnt = '0;
      end else begin
        next_cnt = cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt <= '0;
      done <= 1'b0;
      running <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
      running <= next_running;
    end
  end
endmodule : nvs_timer
`default_nettype wire

//--- nvs_seq.sv
// Store/recall sequencer of a serial nonvolatile SRAM
// Assumes a decoded command strobe from the serial front end on clk_sys;
// pins and supply monitor arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "nvs_cfg.svh"
module nvs_seq
  import nvs_pkg::*;
#(
  parameter int W = `NVS_CW,
  parameter logic [W-1:0] STORE_CYC = W'(`NVS_STORE_CYC),
  parameter logic [W-1:0] WAKE_CYC = W'(`NVS_WAKE_CYC),
  parameter logic [W-1:0] SLEEP_CYC = W'(`NVS_SLEEP_CYC),
  parameter logic [W-1:0] RECALL_CYC = W'(`NVS_RECALL_CYC),
  parameter logic [W-1:0] CMD_CYC = W'(`NVS_CMD_CYC),
  parameter logic [W-1:0] STANDBY_CYC = W'(`NVS_STANDBY_CYC)
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic save_busy_pin_in,
  output logic save_busy_pin_out,
  output logic save_busy_pin_oe_n,
  input wire logic power_low,
  input wire logic cmd_valid,
  input wire nvs_op_t cmd_op,
  input wire logic wake_req,
  input wire logic bus_stop,
  input wire logic sram_write,
  output logic access_enable,
  output logic write_enable,
  output logic nv_store_active,
  output logic nv_recall_active,
  output logic sleeping,
  output logic standby,
  output logic dirty
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic pin_m;
  logic pin_s;
  logic pwr_m;
  logic pwr_s;
  logic pwr_d;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_m <= 1'b1;
      pin_s <= 1'b1;
      pwr_m <= 1'b0;
      pwr_s <= 1'b0;
      pwr_d <= 1'b0;
    end else begin
      pin_m <= save_busy_pin_in;
      pin_s <= pin_m;
      pwr_m <= power_low;
      pwr_s <= pwr_m;
      pwr_d <= pwr_s;
    end
  end

  logic pin_low;
  logic pwr_fall;
  assign pin_low = ~pin_s & save_busy_pin_oe_n;
  assign pwr_fall = pwr_s & ~pwr_d;

  // ----------------------------------------
  // Shared timer
  // ----------------------------------------
  logic tload;
  logic [W-1:0] tcount;
  logic tdone;

  nvs_timer #(.W(W)) u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(tload),
    .count(tcount),
    .done(tdone),
    .running()
  );

  // ----------------------------------------
  // Timer loads; a state lasts exactly its count
  // ----------------------------------------
  localparam logic [W-1:0] HIGH_LOAD = W'(`NVS_HIGH_CYC - 1);
  localparam logic [W-1:0] REL_LOAD = W'(`NVS_REL_CYC - `NVS_REL_LAT);

  function automatic logic [W-1:0] span(input logic [W-1:0] c);
    span = (c > W'(1)) ? c - W'(1) : W'(1);
  endfunction : span

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  nvs_state_t state;
  nvs_state_t next_state;
  nvs_op_t op;
  nvs_op_t next_op;
  logic hw_save;
  logic next_hw_save;
  logic next_dirty;
  logic drv;
  logic next_drv;

  always_comb begin
    next_state = state;
    next_op = op;
    next_hw_save = hw_save;
    next_drv = drv;
    next_dirty = dirty;
    tload = 1'b0;
    tcount = '0;
    if (sram_write && write_enable) begin
      next_dirty = 1'b1;
    end
    unique case (state)
      NVS_IDLE: begin
        if ((pin_low || pwr_fall) && dirty) begin
          next_state = NVS_GRACE;
          next_hw_save = pin_low;
          next_drv = pin_low;
        end else if (pin_low) begin
          next_state = NVS_HOLD;
        end else if (cmd_valid && cmd_op != NVS_OP_NONE) begin
          next_state = NVS_CMD;
          next_op = cmd_op;
        end
      end
      NVS_CMD: begin
        next_state = NVS_IDLE;
        tload = 1'b1;
        unique case (op)
          NVS_OP_STORE: begin
            next_state = NVS_STORE;
            tcount = span(STORE_CYC);
          end
          NVS_OP_RECALL: begin
            next_state = NVS_RECALL;
            tcount = span(RECALL_CYC);
          end
          NVS_OP_SLEEP: begin
            next_state = NVS_SLP_IN;
            tcount = span(SLEEP_CYC);
          end
          NVS_OP_NONE: begin
            tload = 1'b0;
          end
        endcase
      end
      NVS_GRACE: begin
        next_state = NVS_STORE;
        tload = 1'b1;
        tcount = span(STORE_CYC);
      end
      NVS_STORE: begin
        if (tdone) begin
          next_dirty = 1'b0;
          if (hw_save) begin
            next_state = NVS_HIGH;
            tload = 1'b1;
            tcount = HIGH_LOAD;
          end else begin
            next_state = NVS_IDLE;
          end
        end
      end
      NVS_RECALL: begin
        if (tdone) begin
          next_state = NVS_IDLE;
          next_dirty = 1'b0;
        end
      end
      NVS_HIGH: begin
        if (tdone) begin
          next_state = NVS_HOLD;
          next_drv = 1'b0;
          next_hw_save = 1'b0;
        end
      end
      NVS_HOLD: begin
        if (pin_s) begin
          next_state = NVS_REL;
          tload = 1'b1;
          tcount = REL_LOAD;
        end
      end
      NVS_REL: begin
        if (!pin_s) begin
          next_state = NVS_HOLD;
        end else if (tdone) begin
          next_state = NVS_IDLE;
        end
      end
      NVS_SLP_IN: begin
        if (tdone) begin
          next_state = NVS_SLEEP;
        end
      end
      NVS_SLEEP: begin
        if (wake_req) begin
          next_state = NVS_WAKE;
          tload = 1'b1;
          tcount = span(WAKE_CYC);
        end
      end
      NVS_WAKE: begin
        if (tdone) begin
          next_state = NVS_IDLE;
        end
      end
      default: begin
        next_state = NVS_IDLE;
      end
    endcase
    if (state == NVS_RECALL && tdone) begin
      next_dirty = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= NVS_IDLE;
      op <= NVS_OP_NONE;
      hw_save <= 1'b0;
      drv <= 1'b0;
      dirty <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      hw_save <= next_hw_save;
      drv <= next_drv;
      dirty <= next_dirty;
    end
  end

  // ----------------------------------------
  // Standby timing after stop
  // ----------------------------------------
  logic [W-1:0] sb_cnt;
  logic [W-1:0] next_sb_cnt;
  logic next_standby;

  always_comb begin
    next_sb_cnt = sb_cnt;
    next_standby = standby;
    if (!pin_s || cmd_valid || state != NVS_IDLE) begin
      next_sb_cnt = '0;
      next_standby = 1'b0;
    end else if (bus_stop) begin
      next_sb_cnt = STANDBY_CYC;
      next_standby = 1'b0;
    end else if (sb_cnt == W'(1)) begin
      next_sb_cnt = '0;
      next_standby = 1'b1;
    end else if (sb_cnt != '0) begin
      next_sb_cnt = sb_cnt - W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sb_cnt <= '0;
      standby <= 1'b0;
    end else begin
      sb_cnt <= next_sb_cnt;
      standby <= next_standby;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic next_access;
  logic next_write;

  always_comb begin
    next_access = (next_state == NVS_IDLE) && !pwr_s && pin_s;
    next_write = next_access || (next_state == NVS_GRACE);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      access_enable <= 1'b0;
      write_enable <= 1'b0;
      save_busy_pin_out <= 1'b1;
      save_busy_pin_oe_n <= 1'b1;
      nv_store_active <= 1'b0;
      nv_recall_active <= 1'b0;
      sleeping <= 1'b0;
    end else begin
      access_enable <= next_access;
      write_enable <= next_write;
      save_busy_pin_out <= (next_state == NVS_HIGH);
      save_busy_pin_oe_n <= ~next_drv;
      nv_store_active <= (next_state == NVS_STORE) || (next_state == NVS_GRACE);
      nv_recall_active <= (next_state == NVS_RECALL);
      sleeping <= (next_state == NVS_SLEEP);
    end
  end
endmodule : nvs_seq
`default_nettype wire

//--- nvs_seq_assertions.sv
// Port checks for the store/recall sequencer
// Assumes binding into nvs_seq, single clock domain
`timescale 1ns/1ps
`default_nettype none
module nvs_seq_assertions
  import nvs_pkg::*;
#(
  parameter int W = 18,
  parameter logic [W-1:0] STORE_CYC = W'(20),
  parameter logic [W-1:0] WAKE_CYC = W'(20),
  parameter logic [W-1:0] SLEEP_CYC = W'(20),
  parameter logic [W-1:0] RECALL_CYC = W'(20),
  parameter logic [W-1:0] STANDBY_CYC = W'(20)
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic save_busy_pin_in,
  input wire logic save_busy_pin_out,
  input wire logic save_busy_pin_oe_n,
  input wire logic power_low,
  input wire logic cmd_valid,
  input wire nvs_op_t cmd_op,
  input wire logic wake_req,
  input wire logic bus_stop,
  input wire logic sram_write,
  input wire logic access_enable,
  input wire logic write_enable,
  input wire logic nv_store_active,
  input wire logic nv_recall_active,
  input wire logic sleeping,
  input wire logic standby,
  input wire logic dirty
);
  localparam int SMAX = int'(STORE_CYC) + 3;
  localparam int RMAX = int'(RECALL_CYC) + 3;
  localparam int LMAX = int'(SLEEP_CYC) + 4;
  localparam int KMAX = int'(WAKE_CYC) + 4;
  localparam int BMAX = int'(STANDBY_CYC) + 4;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence drive_hi;
    $rose(save_busy_pin_out) && !save_busy_pin_oe_n;
  endsequence
  sequence go_cmd(nvs_op_t op);
    cmd_valid && cmd_op == op && access_enable;
  endsequence
  cmd_start_a: assert property (go_cmd(NVS_OP_STORE) |-> ##2 nv_store_active)
    else $error("store command not acted on");
  store_len_a: assert property ($rose(nv_store_active) |-> ##[1:SMAX] !nv_store_active)
    else $error("save too long");
  recall_len_a: assert property ($rose(nv_recall_active) |-> ##[1:RMAX] !nv_recall_active)
    else $error("restore too long");
  busy_block_a: assert property (nv_recall_active || (nv_store_active && $past(nv_store_active))
    |-> !access_enable && !write_enable)
    else $error("access during operation");
  low_supply_a: assert property (power_low [*4] |-> !access_enable)
    else $error("access at low supply");
  pin_hold_a: assert property (!save_busy_pin_in [*4] |-> !access_enable)
    else $error("access while pin low");
  clean_pin_a: assert property (!dirty && save_busy_pin_oe_n && $fell(save_busy_pin_in)
    |-> save_busy_pin_oe_n [*4])
    else $error("driver on for clean save");
  high_drive_a: assert property (drive_hi |-> ##[1:5] save_busy_pin_oe_n)
    else $error("pin driven high too long");
  release_a: assert property ($rose(save_busy_pin_in) && !power_low
    |-> ##[1:60] (access_enable || !save_busy_pin_in))
    else $error("not active after release");
  sleep_in_a: assert property (go_cmd(NVS_OP_SLEEP) |-> ##[1:LMAX] sleeping)
    else $error("sleep entry late");
  wake_a: assert property (sleeping && wake_req |-> ##[1:KMAX] access_enable)
    else $error("wake late");
  standby_a: assert property (bus_stop && access_enable
    |-> ##[1:BMAX] (standby || !access_enable))
    else $error("standby late");
  dirty_set_a: assert property (sram_write && write_enable && !nv_store_active |=> dirty)
    else $error("write not marked");
endmodule : nvs_seq_assertions
bind nvs_seq nvs_seq_assertions #(.W(W), .STORE_CYC(STORE_CYC), .WAKE_CYC(WAKE_CYC),
  .SLEEP_CYC(SLEEP_CYC), .RECALL_CYC(RECALL_CYC), .STANDBY_CYC(STANDBY_CYC))
  nvs_seq_assertions_i (.clk_sys(clk_sys), .srst(srst), .save_busy_pin_in(save_busy_pin_in),
  .save_busy_pin_out(save_busy_pin_out), .save_busy_pin_oe_n(save_busy_pin_oe_n),
  .power_low(power_low), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .wake_req(wake_req),
  .bus_stop(bus_stop), .sram_write(sram_write), .access_enable(access_enable),
  .write_enable(write_enable), .nv_store_active(nv_store_active),
  .nv_recall_active(nv_recall_active), .sleeping(sleeping), .standby(standby),
  .dirty(dirty));
`default_nettype wire

//--- nvs_host_model.sv
// Host model: command strobes, stop pulses, save pin with pull-up
// Assumes drive on falling clock edge
`timescale 1ns/1ps
`default_nettype none
module nvs_host_model
  import nvs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pin_in,
  output var logic cmd_valid,
  output var nvs_op_t cmd_op,
  output var logic bus_stop
);
  logic host_low;
  // Pin level from both drivers and pull-up
  assign pin_in = !(host_low || (!pin_oe_n && !pin_out));
  initial begin
    host_low = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = NVS_OP_NONE;
    bus_stop = 1'b0;
  end
  task automatic cmd(input nvs_op_t op);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_op = op;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_op = NVS_OP_NONE;
  endtask : cmd
  // Low request held whole cycles, above the minimum width
  task automatic pin(input logic v);
    @(negedge clk_sys);
    host_low = !v;
  endtask : pin
  task automatic stop;
    @(negedge clk_sys);
    bus_stop = 1'b1;
    @(negedge clk_sys);
    bus_stop = 1'b0;
  endtask : stop
endmodule : nvs_host_model
`default_nettype wire

//--- tb_nvs_seq.sv
// Testbench of the store/recall sequencer
// Assumes short timing parameters of 20 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_nvs_seq;
  import nvs_pkg::*;
  localparam logic [17:0] CYC = 18'h14;
  localparam int C = 20;
  logic clk_sys, srst, power_low, wake_req, sram_write, pin_in, pin_out, pin_oe_n;
  logic cmd_valid, bus_stop, acc, wen, st_act, rc_act, sleeping, standby, dirty;
  nvs_op_t cmd_op;
  int error_cnt, compares, n;
  nvs_seq #(.STORE_CYC(CYC), .WAKE_CYC(CYC), .SLEEP_CYC(CYC), .RECALL_CYC(CYC),
    .STANDBY_CYC(CYC)) nvs_seq_i (.clk_sys(clk_sys), .srst(srst),
    .save_busy_pin_in(pin_in), .save_busy_pin_out(pin_out), .save_busy_pin_oe_n(pin_oe_n),
    .power_low(power_low), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .wake_req(wake_req),
    .bus_stop(bus_stop), .sram_write(sram_write), .access_enable(acc), .write_enable(wen),
    .nv_store_active(st_act), .nv_recall_active(rc_act), .sleeping(sleeping),
    .standby(standby), .dirty(dirty));
  nvs_host_model host_i (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .bus_stop(bus_stop));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic conclude;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : cyc
  task automatic wait_acc(input int lim);
    n = 0;
    while (acc !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      $display("unexpected timeout at %0t got %h exp %h", $time, acc, 1'b1);
      conclude();
    end
  endtask : wait_acc
  task automatic wr;
    @(negedge clk_sys);
    sram_write = 1'b1;
    @(negedge clk_sys);
    sram_write = 1'b0;
  endtask : wr
  task automatic t_store;
    wr();
    chk(dirty, 1'b1);
    host_i.cmd(NVS_OP_STORE);
    cyc(2);
    chk(st_act, 1'b1);
    chk(acc, 1'b0);
    chk(wen, 1'b0);
    wr();
    wait_acc(C + 10);
    chk(n <= C + 4, 1'b1);
    chk(dirty, 1'b0);
    $display("store done");
  endtask : t_store
  task automatic t_recall;
    host_i.cmd(NVS_OP_NONE);
    cyc(2);
    chk(acc, 1'b1);
    host_i.cmd(NVS_OP_RECALL);
    cyc(2);
    chk(rc_act, 1'b1);
    wr();
    chk(dirty, 1'b0);
    wait_acc(C + 10);
    chk(n <= C + 4, 1'b1);
    $display("recall done");
  endtask : t_recall
  task automatic t_pin_clean;
    host_i.pin(1'b0);
    cyc(6);
    chk(acc, 1'b0);
    chk(pin_oe_n, 1'b1);
    chk(st_act, 1'b0);
    host_i.pin(1'b1);
    wait_acc(70);
    chk(n <= 50, 1'b1);
    $display("clean pin done");
  endtask : t_pin_clean
  task automatic t_pin_dirty;
    wr();
    host_i.pin(1'b0);
    host_i.pin(1'b1);
    cyc(2);
    chk(wen, 1'b1);
    cyc(2);
    chk(wen, 1'b0);
    chk(pin_oe_n, 1'b0);
    chk(pin_out, 1'b0);
    chk(st_act, 1'b1);
    wait_acc(C + 80);
    chk(dirty, 1'b0);
    chk(pin_oe_n, 1'b1);
    $display("dirty pin done");
  endtask : t_pin_dirty
  task automatic t_power;
    wr();
    power_low = 1'b1;
    cyc(5);
    chk(acc, 1'b0);
    chk(st_act, 1'b1);
    cyc(C + 5);
    chk(dirty, 1'b0);
    power_low = 1'b0;
    wait_acc(70);
    $display("power done");
  endtask : t_power
  task automatic t_sleep;
    host_i.cmd(NVS_OP_SLEEP);
    cyc(C + 4);
    chk(sleeping, 1'b1);
    wake_req = 1'b1;
    cyc(1);
    wake_req = 1'b0;
    wait_acc(C + 10);
    chk(n <= C + 4, 1'b1);
    $display("sleep done");
  endtask : t_sleep
  task automatic t_standby;
    host_i.stop();
    cyc(C + 3);
    chk(standby, 1'b1);
    $display("standby done");
  endtask : t_standby
  initial begin
    srst = 1'b1;
    power_low = 1'b0;
    wake_req = 1'b0;
    sram_write = 1'b0;
    error_cnt = 0;
    compares = 0;
    cyc(6);
    srst = 1'b0;
    wait_acc(20);
    t_store();
    t_recall();
    t_pin_clean();
    t_pin_dirty();
    t_power();
    t_sleep();
    t_standby();
    conclude();
  end
endmodule : tb_nvs_seq
`default_nettype wire
